/* design/dtr_consts.vh */
// constants for the converter trim register bank
`ifndef DTR_CONSTS_VH
`define DTR_CONSTS_VH

`define DTR_ADDR_W 8
`define DTR_DATA_W 32
`define DTR_REG_W 16

// register indices; byte address is four times the index
`define DTR_IDX_GAIN_CH4 6'h04
`define DTR_IDX_GAIN_CH3 6'h05
`define DTR_IDX_GAIN_CH2 6'h06
`define DTR_IDX_GAIN_CH1 6'h07
`define DTR_IDX_RANGE 6'h08
`define DTR_IDX_RES_CH4 6'h09
`define DTR_IDX_RES_CH3 6'h0A
`define DTR_IDX_RES_CH2 6'h0B
`define DTR_IDX_FIRST 6'h04
`define DTR_IDX_LAST 6'h0B
`define DTR_NUM_SLOTS 8

// field layout
`define DTR_GAIN_LSB 0
`define DTR_GAIN_W 7
`define DTR_GAIN_CAL_LSB 8
`define DTR_RANGE_W 2
`define DTR_RES_LSB 0
`define DTR_RES_W 5
`define DTR_RES_CAL_LSB 8
`define DTR_RES_EN_BIT 15

// writable bit masks; calibration fields excluded
`define DTR_GAIN_WMASK 16'h80FF
`define DTR_RANGE_WMASK 16'hFFFF
`define DTR_RES_WMASK 16'hE0FF

// reset values
`define DTR_GAIN_RST 16'h0000
`define DTR_RANGE_RST 16'h0000
`define DTR_RES_RST 16'h000A
`define DTR_CAL_RST 43'h000_0000_0000

// resistor scaling and recommended span
`define DTR_OHMS_PER_CODE 15'h320
`define DTR_OHMS_W 15
`define DTR_RES_CODE_MIN 5'h05
`define DTR_RES_CODE_DEF 5'h0A
`define DTR_RES_CODE_MAX 5'h14

`endif

/* design/dtr_cal_store.v */
// holding register for calibration engine results
`timescale 1ns/1ns
`default_nettype none

module dtr_cal_store #(
   parameter WIDTH = 43
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire load_in,
   input wire clear_in,
   input wire [WIDTH-1:0] data_in,
   output wire [WIDTH-1:0] data_out
);

   reg [WIDTH-1:0] data_reg;
   reg [WIDTH-1:0] data_next;

   always @*
   begin
      data_next = data_reg;
      if (clear_in)
      begin
         data_next = {WIDTH{1'b0}};
      end
      else if (load_in)
      begin
         data_next = data_in;
      end
   end

   always @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         data_reg <= {WIDTH{1'b0}};
      end
      else
      begin
         data_reg <= data_next;
      end
   end

   assign data_out = data_reg;

endmodule // dtr_cal_store

`default_nettype wire

/* design/dtr_trim_regs.v */
// analog trim register bank with apb slave
// Notes on behaviour
// - ch1 signed 7-bit fine gain, calibration overrides
// - ch1 gain calibration result, read only
// - four two-bit range selectors, reset zero
// - range code scales gain span quarters
// - five-bit resistor code, 800 ohm steps
// - codes 0x05 to 0x14 are the span
// - bit 15 writes enable, reads calibration-enabled
// - resistor calibration result, read only
// - three identical resistor registers, consecutive addresses
// - channels 4 to 2 gain registers too
`timescale 1ns/1ns
`default_nettype none
`include "dtr_consts.vh"

module dtr_trim_regs #(
   parameter NUM_GAIN = 4,
   parameter NUM_RES = 3
) (
   input wire sys_clk_in,
   input wire rst_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [`DTR_ADDR_W-1:0] paddr_in,
   input wire [`DTR_DATA_W-1:0] pwdata_in,
   output wire [`DTR_DATA_W-1:0] prdata_out,
   output wire pready_out,
   output wire pslverr_out,
   input wire cal_mode_in,
   input wire cal_load_in,
   input wire cal_clear_in,
   input wire [NUM_GAIN*`DTR_GAIN_W-1:0] gain_cal_in,
   input wire [NUM_RES*`DTR_RES_W-1:0] res_cal_in,
   output wire [NUM_GAIN*`DTR_GAIN_W-1:0] gain_word_out,
   output wire [NUM_GAIN*`DTR_RANGE_W-1:0] range_sel_out,
   output wire [NUM_GAIN*3-1:0] span_quarters_out,
   output wire [NUM_RES*`DTR_RES_W-1:0] res_code_out,
   output wire [NUM_RES-1:0] res_enable_out,
   output wire [NUM_RES*`DTR_OHMS_W-1:0] res_ohms_out,
   output wire [NUM_RES-1:0] res_in_span_out
);

   localparam CAL_W = NUM_GAIN*`DTR_GAIN_W + NUM_RES*`DTR_RES_W;

   // one-hot slot select for a byte address; zero when unmapped
   function [`DTR_NUM_SLOTS-1:0] dtr_decode;
      input [`DTR_ADDR_W-1:0] addr;
      integer k;
      begin
         dtr_decode = {`DTR_NUM_SLOTS{1'b0}};
         for (k = 0; k < `DTR_NUM_SLOTS; k = k + 1)
         begin
            if ((addr[1:0] == 2'b00) && (addr[7:2] == `DTR_IDX_FIRST + k[5:0]))
            begin
               dtr_decode[k] = 1'b1;
            end
         end
      end
   endfunction

   // recommended resistor span check
   function dtr_in_span;
      input [`DTR_RES_W-1:0] code;
      begin
         dtr_in_span = (code >= `DTR_RES_CODE_MIN) && (code <= `DTR_RES_CODE_MAX);
      end
   endfunction

   wire [`DTR_NUM_SLOTS-1:0] sel_w;
   wire setup_w;
   wire access_w;
   wire wr_w;
   wire [CAL_W-1:0] cal_w;
   wire [15:0] rd_word_w [0:`DTR_NUM_SLOTS-1];

   wire [NUM_GAIN*16-1:0] gain_reg;
   reg [15:0] range_reg;
   wire [NUM_RES*16-1:0] res_reg;
   reg [`DTR_DATA_W-1:0] prdata_reg;
   reg [`DTR_DATA_W-1:0] prdata_next;
   reg [15:0] rd_mux;
   wire [NUM_GAIN*`DTR_GAIN_W-1:0] gain_word_reg;
   wire [NUM_RES*`DTR_OHMS_W-1:0] res_ohms_reg;
   wire [NUM_RES-1:0] res_in_span_reg;
   integer m;

   assign sel_w = dtr_decode(paddr_in);
   assign setup_w = psel_in & ~penable_in;
   assign access_w = psel_in & penable_in;
   assign wr_w = access_w & pwrite_in;

   // zero-wait slave; unmapped addresses answer with an error
   assign pready_out = 1'b1;
   assign pslverr_out = access_w & ~(|sel_w);
   assign prdata_out = prdata_reg;

   // calibration results held until reloaded or cleared
   dtr_cal_store #(
      .WIDTH(CAL_W)
   ) u_cal_store (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .load_in(cal_load_in),
      .clear_in(cal_clear_in),
      .data_in({res_cal_in, gain_cal_in}),
      .data_out(cal_w)
   );

   genvar c;
   genvar r;

   // gain registers: channel c+1 sits at slot 3-c
   generate
      for (c = 0; c < NUM_GAIN; c = c + 1)
      begin : g_gain
         wire [`DTR_GAIN_W-1:0] cal_gain_w;
         wire [`DTR_GAIN_W-1:0] fine_w;
         reg [15:0] slot_reg;
         reg [`DTR_GAIN_W-1:0] word_reg;
         assign gain_reg[c*16 +: 16] = slot_reg;
         assign gain_word_reg[c*`DTR_GAIN_W +: `DTR_GAIN_W] = word_reg;
         assign cal_gain_w = cal_w[c*`DTR_GAIN_W +: `DTR_GAIN_W];
         assign fine_w = gain_reg[c*16 + `DTR_GAIN_LSB +: `DTR_GAIN_W];

         always @(posedge sys_clk_in)
         begin
            if (rst_in)
            begin
               slot_reg <= `DTR_GAIN_RST;
            end
            else if (wr_w && sel_w[3-c])
            begin
               slot_reg <= pwdata_in[15:0] & `DTR_GAIN_WMASK;
            end
         end

         assign rd_word_w[3-c] = gain_reg[c*16 +: 16]
            | {1'b0, cal_gain_w, 8'h00};

         always @(posedge sys_clk_in)
         begin
            if (rst_in)
            begin
               word_reg <= {`DTR_GAIN_W{1'b0}};
            end
            else if (cal_mode_in)
            begin
               word_reg <= cal_gain_w;
            end
            else
            begin
               word_reg <= fine_w;
            end
         end

         assign range_sel_out[c*`DTR_RANGE_W +: `DTR_RANGE_W] =
            range_reg[c*`DTR_RANGE_W +: `DTR_RANGE_W];
         // span in quarters of the window
         assign span_quarters_out[c*3 +: 3] =
            {1'b0, range_reg[c*`DTR_RANGE_W +: `DTR_RANGE_W]} + 3'h1;
      end
   endgenerate

   // range register at slot 4
   always @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         range_reg <= `DTR_RANGE_RST;
      end
      else if (wr_w && sel_w[4])
      begin
         range_reg <= pwdata_in[15:0] & `DTR_RANGE_WMASK;
      end
   end

   assign rd_word_w[4] = range_reg;

   // resistor registers: channel r+2 sits at slot 7-r
   generate
      for (r = 0; r < NUM_RES; r = r + 1)
      begin : g_res
         wire [`DTR_RES_W-1:0] code_w;
         wire [`DTR_RES_W-1:0] cal_res_w;
         wire en_w;
         reg [15:0] slot_reg;
         reg [`DTR_OHMS_W-1:0] ohms_reg;
         reg span_reg;
         assign res_reg[r*16 +: 16] = slot_reg;
         assign res_ohms_reg[r*`DTR_OHMS_W +: `DTR_OHMS_W] = ohms_reg;
         assign res_in_span_reg[r] = span_reg;
         assign code_w = res_reg[r*16 + `DTR_RES_LSB +: `DTR_RES_W];
         assign en_w = res_reg[r*16 + `DTR_RES_EN_BIT];
         assign cal_res_w = cal_w[NUM_GAIN*`DTR_GAIN_W + r*`DTR_RES_W +: `DTR_RES_W];

         always @(posedge sys_clk_in)
         begin
            if (rst_in)
            begin
               slot_reg <= `DTR_RES_RST;
            end
            else if (wr_w && sel_w[7-r])
            begin
               slot_reg <= pwdata_in[15:0] & `DTR_RES_WMASK;
            end
         end

         assign rd_word_w[7-r] = {en_w & cal_mode_in,
            res_reg[r*16 + 13 +: 2], cal_res_w, res_reg[r*16 +: 8]};

         assign res_code_out[r*`DTR_RES_W +: `DTR_RES_W] = code_w;
         assign res_enable_out[r] = en_w;

         always @(posedge sys_clk_in)
         begin
            if (rst_in)
            begin
               ohms_reg <= {`DTR_OHMS_W{1'b0}};
               span_reg <= 1'b0;
            end
            else
            begin
               ohms_reg <= {10'h000, code_w} * `DTR_OHMS_PER_CODE;
               span_reg <= dtr_in_span(code_w);
            end
         end
      end
   endgenerate

   // read mux over the selected slot
   always @*
   begin
      rd_mux = 16'h0000;
      for (m = 0; m < `DTR_NUM_SLOTS; m = m + 1)
      begin
         if (sel_w[m])
         begin
            rd_mux = rd_word_w[m];
         end
      end
   end

   // read data captured in setup, shown in access
   always @*
   begin
      prdata_next = prdata_reg;
      if (setup_w && !pwrite_in)
      begin
         prdata_next = {16'h0000, rd_mux};
      end
   end

   always @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         prdata_reg <= 32'h0000_0000;
      end
      else
      begin
         prdata_reg <= prdata_next;
      end
   end

   assign gain_word_out = gain_word_reg;
   assign res_ohms_out = res_ohms_reg;
   assign res_in_span_out = res_in_span_reg;

endmodule // dtr_trim_regs

`default_nettype wire

/* testbench/dtr_trim_regs_monitor.sv */
// port checker for the trim register bank
`timescale 1ns/1ns
`default_nettype none
module dtr_trim_mon #(
   parameter NUM_GAIN = 4,
   parameter NUM_RES = 3
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic pslverr_out,
   input wire logic cal_mode_in,
   input wire logic cal_load_in,
   input wire logic cal_clear_in,
   input wire logic [NUM_GAIN*7-1:0] gain_cal_in,
   input wire logic [NUM_GAIN*7-1:0] gain_word_out,
   input wire logic [NUM_GAIN*2-1:0] range_sel_out,
   input wire logic [NUM_GAIN*3-1:0] span_quarters_out,
   input wire logic [NUM_RES*5-1:0] res_code_out,
   input wire logic [NUM_RES-1:0] res_enable_out,
   input wire logic [NUM_RES*15-1:0] res_ohms_out,
   input wire logic [NUM_RES-1:0] res_in_span_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   wire bad = paddr_in < 8'h10 || paddr_in > 8'h2C || paddr_in[1:0] != 2'h0;
   wire [7:0] wa = (psel_in && penable_in && pwrite_in) ? paddr_in : 8'h00;
   wire [4:0] code = res_code_out[4:0];
   logic [1:0] run;
   // edges since reset release
   always @(posedge sys_clk_in)
      run <= rst_in ? 2'h0 : {run[0], 1'b1};
   a_err_unmapped: assert property (pslverr_out == (psel_in && penable_in && bad))
      else $error("bus error flag wrong");
   a_range_write: assert property (wa == 8'h20 |=> range_sel_out == $past(pwdata_in[7:0]))
      else $error("range lanes wrong");
   a_span_scale: assert property (span_quarters_out[2:0] == {1'b0, range_sel_out[1:0]} + 3'h1)
      else $error("span quarters wrong");
   a_ohms_step: assert property (run[0] |-> res_ohms_out[14:0] == $past(code) * 15'h320)
      else $error("ohms wrong");
   a_span_flag: assert property (run[0] |->
      res_in_span_out[0] == $past(code >= 5'h05 && code <= 5'h14))
      else $error("span flag wrong");
   a_res_write: assert property (wa == 8'h2C |=>
      code == $past(pwdata_in[4:0]) && res_enable_out[0] == $past(pwdata_in[15]))
      else $error("resistor field wrong");
   a_fine_gain: assert property (wa == 8'h1C && !cal_mode_in ##1 !cal_mode_in |=>
      gain_word_out[6:0] == $past(pwdata_in[6:0], 2))
      else $error("fine gain wrong");
   a_cal_gain: assert property (cal_load_in && !cal_clear_in ##1 cal_mode_in |=>
      gain_word_out[6:0] == $past(gain_cal_in[6:0], 2))
      else $error("cal gain wrong");
   c_res_write: cover property (wa == 8'h2C);
   c_cal_load: cover property (cal_load_in ##1 cal_mode_in);
   c_bus_err: cover property (pslverr_out);
endmodule // dtr_trim_mon
bind dtr_trim_regs dtr_trim_mon #(.NUM_GAIN(NUM_GAIN), .NUM_RES(NUM_RES)) u_mon (.*);
`default_nettype wire

/* testbench/dac_analog_trim_registers_tb_top.sv */
// self-checking bench for the trim register bank
`timescale 1ns/1ns
`default_nettype none
module dac_analog_trim_registers_tb_top;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, d;
   logic cal_mode_in = 1'b0, cal_load_in = 1'b0, cal_clear_in = 1'b0;
   logic [27:0] gain_cal_in = 28'h0;
   logic [14:0] res_cal_in = 15'h0;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out;
   wire [27:0] gain_word_out;
   wire [7:0] range_sel_out;
   wire [11:0] span_quarters_out;
   wire [14:0] res_code_out;
   wire [2:0] res_enable_out, res_in_span_out;
   wire [44:0] res_ohms_out;
   logic [31:0] expq[$];
   logic [4:0] codes[4] = '{5'h04, 5'h05, 5'h14, 5'h15};
   integer seed = 32'h8113;
   integer mismatches = 0, total_checks = 0, i, k;
   dtr_trim_regs DUT (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .cal_mode_in(cal_mode_in),
      .cal_load_in(cal_load_in),
      .cal_clear_in(cal_clear_in),
      .gain_cal_in(gain_cal_in),
      .res_cal_in(res_cal_in),
      .gain_word_out(gain_word_out),
      .range_sel_out(range_sel_out),
      .span_quarters_out(span_quarters_out),
      .res_code_out(res_code_out),
      .res_enable_out(res_enable_out),
      .res_ohms_out(res_ohms_out),
      .res_in_span_out(res_in_span_out)
   );
   always #5 sys_clk_in = ~sys_clk_in;
   task chk(input logic [47:0] exp, input logic [47:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      begin
         @(posedge sys_clk_in);
         psel_in <= 1'b1;
         pwrite_in <= w;
         paddr_in <= a;
         pwdata_in <= v;
         @(posedge sys_clk_in);
         penable_in <= 1'b1;
         @(posedge sys_clk_in);
         while (pready_out !== 1'b1)
         begin
            @(posedge sys_clk_in);
         end
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] v);
      begin
         expq.push_back(v);
         apb(1'b0, a, 32'h0);
      end
   endtask
   // read data checked at the access edge
   always @(posedge sys_clk_in)
      if (psel_in && penable_in && !pwrite_in && pready_out)
         chk(expq.pop_front(), prdata_out);
   initial
   begin
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      for (i = 4; i < 12; i = i + 1)
         rd(8'(i * 4), (i > 8) ? 32'hA : 32'h0);
      chk({3{15'h1F40}}, res_ohms_out);
      chk(3'h7, res_in_span_out);
      rd(8'h30, 32'h0);
      rd(8'h1E, 32'h0);
      // random words on every gain register; only bits 15 and 7:0 read back
      for (i = 4; i < 8; i = i + 1)
      begin
         d = $random(seed);
         apb(1'b1, 8'(i * 4), d);
         rd(8'(i * 4), d & 32'h80FF);
      end
      chk(d[6:0], gain_word_out[6:0]);
      d = ($random(seed) & 32'hFF00) | 32'hE4;
      apb(1'b1, 8'h20, d);
      rd(8'h20, d & 32'hFFFF);
      for (k = 0; k < 4; k = k + 1)
         chk(d[2*k +: 2] + 3'h1, span_quarters_out[3*k +: 3]);
      for (k = 0; k < 3; k = k + 1)
         for (i = 0; i < 4; i = i + 1)
         begin
            apb(1'b1, 8'h24 + 8'(4 * k), 32'hFFFF_FFE0 | codes[i]);
            rd(8'h24 + 8'(4 * k), 32'h60E0 | codes[i]);
            chk(codes[i], res_code_out[5*(2-k) +: 5]);
            chk(1'b1, res_enable_out[2-k]);
            chk(codes[i] * 15'h320, res_ohms_out[15*(2-k) +: 15]);
            chk(codes[i] >= 5'h05 && codes[i] <= 5'h14, res_in_span_out[2-k]);
         end
      apb(1'b1, 8'h1C, 32'h8005);
      cal_mode_in <= 1'b1;
      gain_cal_in <= 28'($random(seed));
      res_cal_in <= 15'($random(seed));
      cal_load_in <= 1'b1;
      @(posedge sys_clk_in);
      cal_load_in <= 1'b0;
      rd(8'h1C, {16'h0, 1'b1, gain_cal_in[6:0], 8'h05});
      rd(8'h2C, {16'h0, 3'h7, res_cal_in[4:0], 8'hF5});
      chk(gain_cal_in[6:0], gain_word_out[6:0]);
      cal_load_in <= 1'b1;
      cal_clear_in <= 1'b1;
      @(posedge sys_clk_in);
      cal_load_in <= 1'b0;
      cal_clear_in <= 1'b0;
      rd(8'h1C, 32'h8005);
      rd(8'h2C, 32'hE0F5);
      @(posedge sys_clk_in);
      test_done;
   end
   initial
   begin
      #50000;
      mismatches = mismatches + 1;
      test_done;
   end
endmodule // dac_analog_trim_registers_tb_top
`default_nettype wire
